/* File: mii_status_pkg.sv */
// constants shared by the receive-side status signalling block
// assumes a 20 MHz core clock that oversamples the recovered receive clock
package mii_status_pkg;

    localparam int unsigned CORE_CLK_KHZ   = 20000;
    localparam int unsigned RX_CLK_10_KHZ  = 2500;
    localparam int unsigned RX_CLK_100_KHZ = 25000;
    localparam int unsigned RX_CLK_1G_KHZ  = 125000;

    localparam int unsigned BYTE_W   = 8;
    localparam int unsigned NIBBLE_W = 4;
    localparam int unsigned SPEED_W  = 2;

    // synchronised bundle: clk, rxAct, txAct, err, dv, data, speed, duplex, rgmii
    localparam int unsigned SYNC_W = 6 + BYTE_W + SPEED_W + 1;

    localparam logic [SPEED_W-1:0] SPEED_10   = 2'h0;
    localparam logic [SPEED_W-1:0] SPEED_100  = 2'h1;
    localparam logic [SPEED_W-1:0] SPEED_1000 = 2'h2;

    localparam logic [NIBBLE_W-1:0] NIBBLE_ZERO = 4'h0;
    localparam logic [BYTE_W-1:0]   BYTE_ZERO   = 8'h00;

endpackage

/* File: sync_2ff.sv */
// two-stage synchroniser for a bundle of asynchronous levels
// assumes each bit is a level that stays put for several core clocks
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             en,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] stable_q;
    logic [WIDTH-1:0] stable_d;

    // first stage is read only by the second
    always_comb begin
        meta_d   = en ? asyncIn : meta_q;
        stable_d = en ? meta_q : stable_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= '0;
            stable_q <= '0;
        end else begin
            meta_q   <= meta_d;
            stable_q <= stable_d;
        end
    end

    assign syncOut = stable_q;
endmodule
`default_nettype wire

/* File: mii_rx_status.sv */
// receive-side status signalling towards the mac: clock, data valid, error,
// collision and carrier sense over mii or gmii, carrier sense held low in gmii full duplex; clock, control and data over rgmii
// assumes every input is asynchronous to core_clk and the recovered receive
// clock is slow enough to be oversampled; data is held a full receive clock
`timescale 1ns/1ps
`default_nettype none
module mii_rx_status
    import mii_status_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              clkEn,
    input  wire logic              recClk,
    input  wire logic              rxActive,
    input  wire logic              txActive,
    input  wire logic              rxErrDet,
    input  wire logic              rxDataValid,
    input  wire logic [BYTE_W-1:0] rxDataIn,
    input  wire logic [SPEED_W-1:0] speedSel,
    input  wire logic              fullDuplex,
    input  wire logic              rgmiiSel,
    output logic                   rxClk,
    output logic                   rxDv,
    output logic                   rxCtl,
    output logic      [BYTE_W-1:0] rxData,
    output logic                   rxErr,
    output logic                   col,
    output logic                   crs
);
    logic [SYNC_W-1:0]  syncVec;
    logic               rxClkS;
    logic               rxActS;
    logic               txActS;
    logic               errS;
    logic               dvS;
    logic [BYTE_W-1:0]  dataS;
    logic [SPEED_W-1:0] speedS;
    logic               fdS;
    logic               rgmiiS;
    logic               gigS;
    logic               rise;
    logic               fall;

    logic              rxClkOut_q;
    logic              rxClkOut_d;
    logic              rxErr_q;
    logic              rxErr_d;
    logic              rxDv_q;
    logic              rxDv_d;
    logic              rxCtl_q;
    logic              rxCtl_d;
    logic [BYTE_W-1:0] rxData_q;
    logic [BYTE_W-1:0] rxData_d;
    logic              col_q;
    logic              col_d;
    logic              crs_q;
    logic              crs_d;

    sync_2ff #(
        .WIDTH   (SYNC_W)
    ) u_sync (
        .clk     (core_clk),
        .rst_n   (rst_n),
        .en      (clkEn),
        .asyncIn ({recClk, rxActive, txActive, rxErrDet, rxDataValid,
                   rxDataIn, speedSel, fullDuplex, rgmiiSel}),
        .syncOut (syncVec)
    );

    assign {rxClkS, rxActS, txActS, errS, dvS, dataS, speedS, fdS, rgmiiS} = syncVec;
    assign gigS = (speedS == SPEED_1000);
    // edges of the recovered clock: outputs follow them, as the mac samples them
    assign rise = rxClkS & ~rxClkOut_q;
    assign fall = ~rxClkS & rxClkOut_q;

    // receive path, stepped by the recovered clock
    always_comb begin
        rxClkOut_d = rxClkS;
        rxErr_d    = rxErr_q;
        rxDv_d     = rxDv_q;
        rxCtl_d    = rxCtl_q;
        rxData_d   = rxData_q;
        if (rise) begin
            if (rgmiiS) begin
                rxCtl_d  = dvS;
                rxData_d = {NIBBLE_ZERO, dataS[NIBBLE_W-1:0]};
            end else begin
                rxErr_d  = errS;
                rxDv_d   = dvS;
                rxCtl_d  = 1'b0;
                rxData_d = gigS ? dataS : {NIBBLE_ZERO, dataS[NIBBLE_W-1:0]};
            end
        end else if (fall && rgmiiS) begin
            rxCtl_d  = dvS ^ errS;
            rxData_d = {NIBBLE_ZERO, dataS[BYTE_W-1:NIBBLE_W]};
        end
        if (rgmiiS) begin
            rxErr_d = 1'b0;
            rxDv_d  = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxClkOut_q <= 1'b0;
            rxErr_q    <= 1'b0;
            rxDv_q     <= 1'b0;
            rxCtl_q    <= 1'b0;
            rxData_q   <= BYTE_ZERO;
        end else if (clkEn) begin
            rxClkOut_q <= rxClkOut_d;
            rxErr_q    <= rxErr_d;
            rxDv_q     <= rxDv_d;
            rxCtl_q    <= rxCtl_d;
            rxData_q   <= rxData_d;
        end
    end

    // collision and carrier sense, not tied to any mii clock
    always_comb begin
        col_d = 1'b0;
        crs_d = 1'b0;
        if (rgmiiS) begin
            col_d = 1'b0;
            crs_d = 1'b0;
        end else if (!fdS) begin
            col_d = rxActS & txActS;
            crs_d = rxActS | txActS;
        end else if (!gigS) begin
            crs_d = rxActS;
        end else begin
            crs_d = 1'b0;
        end
    end

    // collision leaves unaligned to any mii clock; the mac resynchronises it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            col_q <= 1'b0;
            crs_q <= 1'b0;
        end else if (clkEn) begin
            col_q <= col_d;
            crs_q <= crs_d;
        end
    end

    assign rxClk  = rxClkOut_q;
    assign rxErr  = rxErr_q;
    assign rxDv   = rxDv_q;
    assign rxCtl  = rxCtl_q;
    assign rxData = rxData_q;
    assign col    = col_q;
    assign crs    = crs_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    chk_rxerr_stable: assert property (
        !(clkEn && rise) |=> $stable(rxErr_q))
        else $error("receive error changed off a receive clock edge");

    chk_rxerr_value: assert property (
        (clkEn && rise && !rgmiiS) |=> (rxErr_q == $past(errS)))
        else $error("receive error does not follow detector");

    chk_rxerr_rgmii: assert property (
        (clkEn && rgmiiS) |=> !rxErr_q && !rxDv_q)
        else $error("receive error or valid active under rgmii");

    chk_col_half: assert property (
        (clkEn && !rgmiiS && !fdS && rxActS && txActS) |=> col_q)
        else $error("collision missed in half duplex");

    chk_col_quiet: assert property (
        (clkEn && (fdS || rgmiiS || !rxActS || !txActS)) |=> !col_q)
        else $error("collision raised without overlap or in full duplex");

    chk_crs_half: assert property (
        (clkEn && !rgmiiS && !fdS) |=> (crs_q == ($past(rxActS) || $past(txActS))))
        else $error("carrier sense wrong in half duplex");

    chk_crs_full: assert property (
        (clkEn && !rgmiiS && fdS && !gigS) |=> (crs_q == $past(rxActS)))
        else $error("carrier sense wrong in full duplex");

    chk_crs_unused: assert property (
        (clkEn && (rgmiiS || (fdS && gigS))) |=> !crs_q)
        else $error("carrier sense not held low");

    chk_clk_forward: assert property (
        clkEn |=> (rxClkOut_q == $past(rxClkS)))
        else $error("receive clock not forwarded");

    chk_dv_lanes: assert property (
        (clkEn && rise && !rgmiiS && !gigS) |=> (rxDv_q == $past(dvS))
            && (rxData_q[BYTE_W-1:NIBBLE_W] == NIBBLE_ZERO))
        else $error("mii valid or upper lanes wrong");

    chk_ctl_edges: assert property (
        (clkEn && fall && rgmiiS) |=> (rxCtl_q == ($past(dvS) ^ $past(errS))))
        else $error("rgmii control wrong on falling edge");

    cov_collision: cover property (clkEn && !fdS && col_q);
    cov_rgmii_err: cover property (rgmiiS && fall && dvS && errS);
    cov_gig_frame: cover property (gigS && !rgmiiS && rxDv_q);
    cov_full_crs:  cover property (fdS && !gigS && crs_q);
endmodule
`default_nettype wire

/* File: mii_mac_model.sv */
// far-side mac model: synchronises collision, gates carrier sense by mode
// assumes col/crs come straight from the status block, core_clk as mac clock
`timescale 1ns/1ps
`default_nettype none
module mii_mac_model
    import mii_status_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               col,
    input  wire logic               crs,
    input  wire logic [SPEED_W-1:0] speedSel,
    input  wire logic               fullDuplex,
    output logic                    colSeen,
    output logic                    crsSeen
);
    logic [1:0] colSync;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            colSync <= 2'h0;
        end else begin
            colSync <= {colSync[0], col};
        end
    end
    assign colSeen = colSync[1];
    // crs carries nothing in gigabit full duplex
    assign crsSeen = crs & ~(fullDuplex & (speedSel == SPEED_1000));
endmodule
`default_nettype wire

/* File: mii_rx_status_bench.sv */
// self-checking bench for the receive status block
// assumes the mac model beside it; recClk made here with a 400 ns period
`timescale 1ns/1ps
`default_nettype none
module mii_rx_status_bench
    import mii_status_pkg::*;
;
    // bench recovered clock period in core cycles
    localparam logic [7:0] REC_CYCLES = 8'h08;
    logic core_clk = 1'b0, rst_n = 1'b0, recClk = 1'b0;
    logic rxActive = 1'b0, txActive = 1'b0, rxErrDet = 1'b0, rxDataValid = 1'b0;
    logic [BYTE_W-1:0] rxDataIn = 8'h00;
    logic [SPEED_W-1:0] speedSel = SPEED_10;
    logic fullDuplex = 1'b0, rgmiiSel = 1'b0;
    logic rxClk, rxDv, rxCtl, rxErr, col, crs, colSeen, crsSeen;
    logic [BYTE_W-1:0] rxData;
    logic [1:0] recCnt = 2'h0;
    int mismatches = 0, nChecks = 0;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        recCnt <= recCnt + 2'h1;
        if (recCnt == 2'h3) recClk <= ~recClk;
    end
    mii_rx_status dut_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1),
        .recClk(recClk), .rxActive(rxActive), .txActive(txActive),
        .rxErrDet(rxErrDet), .rxDataValid(rxDataValid), .rxDataIn(rxDataIn),
        .speedSel(speedSel), .fullDuplex(fullDuplex), .rgmiiSel(rgmiiSel),
        .rxClk(rxClk), .rxDv(rxDv), .rxCtl(rxCtl), .rxData(rxData),
        .rxErr(rxErr), .col(col), .crs(crs));
    mii_mac_model mac_u (.core_clk(core_clk), .rst_n(rst_n), .col(col), .crs(crs),
        .speedSel(speedSel), .fullDuplex(fullDuplex), .colSeen(colSeen),
        .crsSeen(crsSeen));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic setup(input logic [1:0] spd, input logic fd, input logic rg,
                         input logic rx, input logic tx);
        @(posedge core_clk);
        speedSel <= spd;
        fullDuplex <= fd;
        rgmiiSel <= rg;
        rxActive <= rx;
        txActive <= tx;
        cyc(5);
    endtask
    // wait for a fresh forwarded rising edge, outputs sampled at that edge
    task automatic waitRise();
        int i;
        for (i = 0; i < 40 && rxClk !== 1'b0; i++) cyc(1);
        for (i = 0; i < 40 && rxClk !== 1'b1; i++) cyc(1);
        if (rxClk !== 1'b1) begin
            mismatches++;
            finish_test();
        end
    endtask
    // wait for a fresh forwarded falling edge, outputs sampled at that edge
    task automatic waitFall();
        int i;
        for (i = 0; i < 40 && rxClk !== 1'b1; i++) cyc(1);
        for (i = 0; i < 40 && rxClk !== 1'b0; i++) cyc(1);
        if (rxClk !== 1'b0) begin
            mismatches++;
            finish_test();
        end
    endtask
    // forwarded clock keeps the period of the recovered clock
    task automatic clock_scenario();
        int i;
        int n;
        n = 0;
        waitRise();
        for (i = 0; i < 40 && rxClk === 1'b1; i++) begin
            cyc(1);
            n++;
        end
        for (i = 0; i < 40 && rxClk === 1'b0; i++) begin
            cyc(1);
            n++;
        end
        check(8'(n), REC_CYCLES);
    endtask
    task automatic status_scenario();
        setup(SPEED_100, 1'b0, 1'b0, 1'b1, 1'b1);
        check(col, 1'b1);
        check(crs, 1'b1);
        check(colSeen, 1'b1);
        setup(SPEED_10, 1'b0, 1'b0, 1'b0, 1'b1);
        check(col, 1'b0);
        check(crs, 1'b1);
        setup(SPEED_100, 1'b1, 1'b0, 1'b1, 1'b1);
        check(col, 1'b0);
        check(crs, 1'b1);
        check(crsSeen, 1'b1);
        setup(SPEED_10, 1'b1, 1'b0, 1'b0, 1'b1);
        check(crs, 1'b0);
        setup(SPEED_1000, 1'b1, 1'b0, 1'b1, 1'b1);
        check(crs, 1'b0);
        check(crsSeen, 1'b0);
        setup(SPEED_1000, 1'b0, 1'b1, 1'b1, 1'b1);
        check(col, 1'b0);
        check(crs, 1'b0);
    endtask
    task automatic rx_scenario(input logic [1:0] spd, input logic rg,
                               input logic [7:0] expData);
        setup(spd, 1'b0, rg, 1'b0, 1'b0);
        @(posedge core_clk);
        rxDataValid <= 1'b1;
        rxErrDet <= 1'b1;
        rxDataIn <= 8'hA5;
        cyc(8);
        waitRise();
        check(rxDv, !rg);
        check(rxErr, !rg);
        if (rg) check(rxCtl, 1'b1);
        else check(rxCtl, 1'b0);
        check(rxData, expData);
        if (rg) begin
            waitFall();
            check(rxCtl, 1'b0);
            check(rxData, 8'h0A);
        end
        @(posedge core_clk);
        rxDataValid <= 1'b0;
        rxErrDet <= 1'b0;
        cyc(8);
        waitRise();
        check(rxErr, 1'b0);
        check(rxDv, 1'b0);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        status_scenario();
        clock_scenario();
        rx_scenario(SPEED_1000, 1'b0, 8'hA5);
        rx_scenario(SPEED_100, 1'b0, 8'h05);
        rx_scenario(SPEED_1000, 1'b1, 8'h05);
        finish_test();
    end
endmodule
`default_nettype wire
